/* File: bfa_map.vh */
// register offsets, field positions and frame constants for the beacon frame assembler
`ifndef BFA_MAP_VH
`define BFA_MAP_VH
`define BFA_CTRL 12'h000
`define BFA_FC 12'h004
`define BFA_DEST 12'h008
`define BFA_SRC 12'h00c
`define BFA_SEQ 12'h010
`define BFA_ACC 12'h014
`define BFA_CAP 12'h018
`define BFA_BODY 12'h01c
`define BFA_STAT 12'h020
`define BFA_FC_VER_LSB 0
`define BFA_FC_SEC_BIT 3
`define BFA_FC_ACK_LSB 4
`define BFA_FC_TYPE_LSB 6
`define BFA_FC_SUB_LSB 9
`define BFA_FC_RETRY_BIT 13
`define BFA_CTRL_START_BIT 0
`define BFA_CTRL_CLR_BIT 1
`define BFA_HDR_LEN 4'h9
`define BFA_CAP_ID 8'h0c
`define BFA_CAP_LEN 8'h02
`define BFA_CRC_INIT 32'hffffffff
`define BFA_CRC_POLY 32'hedb88320
`define BFA_FIFO_DEPTH 16
`endif

/* File: bfa_assembler.v */
// beacon frame assembler: apb registers, body fifo, octet sequencer and fcs
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "bfa_map.vh"

module bfa_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16
) (
    input wire mclk,
    input wire rst_b,
    input wire clear,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    localparam AW = $clog2(DEPTH);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    always @(posedge mclk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (clear) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

module bfa_assembler (
    input wire mclk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [7:0] tx_data,
    output reg tx_valid,
    output reg tx_first,
    output reg tx_last,
    input wire tx_ready
);
    localparam ST_IDLE = 3'h0;
    localparam ST_HDR = 3'h1;
    localparam ST_CAP = 3'h2;
    localparam ST_BODY = 3'h3;
    localparam ST_FCS = 3'h4;

    reg [15:0] fc_word;
    reg [15:0] dest_addr;
    reg [15:0] source_address;
    reg [15:0] seq_ctrl;
    reg [15:0] access_info;
    reg [8:0] cap_flags;
    reg [2:0] state;
    reg [3:0] idx;
    reg [31:0] crc;
    reg frames_done;
    reg [15:0] frame_count;
    wire [7:0] fifo_data;
    wire fifo_valid;
    wire fifo_in_ready;
    reg fifo_pop;
    wire acc = psel && penable && !pready;
    wire wr = acc && pwrite;
    wire body_push = wr && (paddr == `BFA_BODY);
    wire ctl_wr = wr && (paddr == `BFA_CTRL);
    wire start = ctl_wr && pwdata[`BFA_CTRL_START_BIT] && (state == ST_IDLE);
    wire clr = ctl_wr && pwdata[`BFA_CTRL_CLR_BIT] && (state == ST_IDLE);
    // body end is marked by bit 8 of the body word written last
    wire [8:0] body_word;

    function [31:0] crc_byte;
        input [31:0] c;
        input [7:0] d;
        integer i;
        reg [31:0] r;
        begin
            r = c ^ {24'h000000, d};
            for (i = 0; i < 8; i = i + 1)
                r = r[0] ? ((r >> 1) ^ `BFA_CRC_POLY) : (r >> 1);
            crc_byte = r;
        end
    endfunction

    // header octet by index, low octet of each field first
    function [7:0] hdr_octet;
        input [3:0] k;
        begin
            case (k)
                4'h0: hdr_octet = fc_word[7:0];
                4'h1: hdr_octet = fc_word[15:8];
                4'h2: hdr_octet = dest_addr[7:0];
                4'h3: hdr_octet = dest_addr[15:8];
                4'h4: hdr_octet = source_address[7:0];
                4'h5: hdr_octet = source_address[15:8];
                4'h6: hdr_octet = seq_ctrl[7:0];
                4'h7: hdr_octet = seq_ctrl[15:8];
                4'h8: hdr_octet = access_info[7:0];
                default: hdr_octet = access_info[15:8];
            endcase
        end
    endfunction

    bfa_fifo #(.WIDTH(9), .DEPTH(`BFA_FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .clear(clr),
        .in_data(pwdata[8:0]),
        .in_valid(body_push),
        .in_ready(fifo_in_ready),
        .out_data(body_word),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );
    assign fifo_data = body_word[7:0];

    wire can_send = !tx_valid || tx_ready;
    wire [7:0] cap_octet = (idx[1:0] == 2'h0) ? `BFA_CAP_ID :
        (idx[1:0] == 2'h1) ? `BFA_CAP_LEN :
        (idx[1:0] == 2'h2) ? cap_flags[7:0] :
        {7'h00, cap_flags[8]};

    always @* begin
        fifo_pop = (state == ST_BODY) && can_send && fifo_valid;
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            fc_word <= 16'h0000;
            dest_addr <= 16'hffff;
            source_address <= 16'h0000;
            seq_ctrl <= 16'h0000;
            access_info <= 16'h0000;
            cap_flags <= 9'h000;
        end else begin
            // body writes stall in access phase while the fifo is full
            pready <= acc && !(body_push && !fifo_in_ready);
            pslverr <= 1'b0;
            if (acc && !(body_push && !fifo_in_ready)) begin
                prdata <= 32'h00000000;
                case (paddr)
                    `BFA_CTRL: prdata <= 32'h00000000;
                    `BFA_FC: begin
                        if (pwrite)
                            fc_word <= {2'b00, pwdata[13:0]};
                        prdata <= {16'h0000, fc_word};
                    end
                    `BFA_DEST: begin
                        if (pwrite)
                            dest_addr <= pwdata[15:0];
                        prdata <= {16'h0000, dest_addr};
                    end
                    `BFA_SRC: begin
                        if (pwrite)
                            source_address <= pwdata[15:0];
                        prdata <= {16'h0000, source_address};
                    end
                    `BFA_SEQ: begin
                        if (pwrite)
                            seq_ctrl <= pwdata[15:0];
                        prdata <= {16'h0000, seq_ctrl};
                    end
                    `BFA_ACC: begin
                        if (pwrite)
                            access_info <= pwdata[15:0];
                        prdata <= {16'h0000, access_info};
                    end
                    `BFA_CAP: begin
                        if (pwrite)
                            cap_flags <= pwdata[8:0];
                        prdata <= {23'h000000, cap_flags};
                    end
                    `BFA_BODY: prdata <= 32'h00000000;
                    `BFA_STAT: prdata <= {frame_count, 8'h00, 3'h0, fifo_valid, frames_done, state};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            idx <= 4'h0;
            crc <= `BFA_CRC_INIT;
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
            tx_first <= 1'b0;
            tx_last <= 1'b0;
            frames_done <= 1'b0;
            frame_count <= 16'h0000;
        end else begin
            if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
                tx_first <= 1'b0;
                tx_last <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_HDR;
                        idx <= 4'h0;
                        crc <= `BFA_CRC_INIT;
                        frames_done <= 1'b0;
                    end
                end
                ST_HDR: if (can_send) begin
                    tx_data <= hdr_octet(idx);
                    tx_valid <= 1'b1;
                    tx_first <= (idx == 4'h0);
                    idx <= idx + 4'h1;
                    if (idx == `BFA_HDR_LEN) begin
                        // beacon parameters come from the fifo ahead of the capability element
                        state <= ST_BODY;
                        idx <= 4'h0;
                    end
                end
                ST_BODY: if (can_send) begin
                    if (fifo_valid) begin
                        tx_data <= fifo_data;
                        tx_valid <= 1'b1;
                        crc <= crc_byte(crc, fifo_data);
                        if (body_word[8]) begin
                            state <= ST_CAP;
                            idx <= 4'h0;
                        end
                    end
                end
                ST_CAP: if (can_send) begin
                    // capability element closes the element sequence
                    tx_data <= cap_octet;
                    crc <= crc_byte(crc, cap_octet);
                    tx_valid <= 1'b1;
                    idx <= idx + 4'h1;
                    if (idx == 4'h3) begin
                        state <= ST_FCS;
                        idx <= 4'h0;
                    end
                end
                ST_FCS: if (can_send) begin
                    // complemented crc, low octet first
                    tx_data <= ~crc[{idx[1:0], 3'b000} +: 8];
                    tx_valid <= 1'b1;
                    tx_last <= (idx == 4'h3);
                    idx <= idx + 4'h1;
                    if (idx == 4'h3) begin
                        state <= ST_IDLE;
                        frames_done <= 1'b1;
                        frame_count <= frame_count + 16'h0001;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: bfa_assembler_checker.sv */
// port assertions for the beacon frame assembler
`timescale 1ns/1ps
`default_nettype none
module bfa_assembler_checker (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_first,
    input wire logic tx_last,
    input wire logic tx_ready
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence access_s;
        psel && penable && !pready;
    endsequence
    sequence taken_s;
        tx_valid && tx_ready;
    endsequence
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("pready unasked");
    // only body writes may stall on a full fifo
    answer_time_a: assert property (access_s ##0 paddr != 12'h01c |=> pready) else $error("answer late");
    unmapped_err_a: assert property (pready && paddr > 12'h020 |-> pslverr && prdata == 32'h0)
        else $error("unmapped not refused");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr stray");
    octet_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("octet dropped");
    first_then_fc_a: assert property (taken_s ##0 tx_first |=> tx_valid && !tx_first && tx_data[7:6] == 2'b00)
        else $error("bad fc high octet");
    last_then_idle_a: assert property (taken_s ##0 tx_last |=> !tx_valid) else $error("octet after fcs");
    marks_valid_a: assert property (tx_first || tx_last |-> tx_valid) else $error("mark without octet");
endmodule
bind bfa_assembler bfa_assembler_checker chk_u (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready));
`default_nettype wire

/* File: bfa_phy_sink.sv */
// phy transmit side: takes octets at once or with random stalls
`timescale 1ns/1ps
`default_nettype none
module bfa_phy_sink (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic slow,
    output logic tx_ready
);
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            tx_ready <= 1'b0;
        else
            tx_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
    end
endmodule
`default_nettype wire

/* File: beacon_frame_assembler_bench.sv */
// self-checking bench: apb stimulus, octet stream model and fcs check
`timescale 1ns/1ps
`default_nettype none
`define BFA_CHK(got, want) begin n_tests++; if ((got) !== (want)) begin n_errors++; \
    $display("[ERR] %0t got %h want %h", $time, got, want); end end
module beacon_frame_assembler_bench;
    logic mclk = 1'b0, rst_b, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, e;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, tx_valid, tx_first, tx_last, tx_ready;
    logic [7:0] tx_data, b;
    logic [7:0] exp_q[$];
    logic [31:0] rv[7] = '{32'h0, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0};
    int n_errors = 0, n_tests = 0, cyc = 0, pos = 0, nf = 0;
    bfa_assembler dut_u (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready));
    bfa_phy_sink phy_u (.mclk(mclk), .rst_b(rst_b), .slow(slow), .tx_ready(tx_ready));
    always #25 mclk = ~mclk;
    task automatic wrap_up;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (tx_valid && tx_ready) begin
            b = exp_q.pop_front();
            `BFA_CHK(tx_first, 1'(pos == 0))
            `BFA_CHK(tx_data, b)
            `BFA_CHK(tx_last, 1'(exp_q.size() == 0))
            pos = tx_last ? 0 : pos + 1;
        end
        if (cyc == 30000) begin
            n_errors++;
            wrap_up();
        end
    end
    // pready, read data and error are taken at the rising edge that ends the access, then released
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] crc(input logic [31:0] c, input logic [7:0] d);
        c = c ^ {24'h0, d};
        for (int i = 0; i < 8; i++)
            c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        return c;
    endfunction
    // bodies past 16 octets are written after start, so the full fifo stalls the write
    task automatic frame(input int n, input logic s);
        logic [15:0] f;
        logic [8:0] cap;
        logic [31:0] c;
        logic [7:0] p[$];
        c = 32'hffffffff;
        slow <= s;
        for (int i = 0; i < 5; i++) begin
            f = 16'($urandom);
            apb(1'b1, 12'(4 + 4 * i), {16'h0, f});
            if (i == 0) begin
                f[15:14] = 2'b00;
                apb(1'b0, 12'h004, 32'h0);
                `BFA_CHK(r, {16'h0, f})
                `BFA_CHK(e, 1'b0)
            end
            exp_q.push_back(f[7:0]);
            exp_q.push_back(f[15:8]);
        end
        cap = 9'($urandom);
        apb(1'b1, 12'h018, {23'h0, cap});
        for (int i = 0; i < n; i++)
            p.push_back(8'($urandom));
        p.push_back(8'h0c);
        p.push_back(8'h02);
        p.push_back(cap[7:0]);
        p.push_back({7'h0, cap[8]});
        foreach (p[i]) begin
            exp_q.push_back(p[i]);
            c = crc(c, p[i]);
        end
        c = ~c;
        for (int i = 0; i < 4; i++)
            exp_q.push_back(c[8 * i +: 8]);
        for (int i = 0; i < n && i < 16; i++)
            apb(1'b1, 12'h01c, {23'h0, 1'(i == n - 1), p[i]});
        apb(1'b1, 12'h000, 32'h1);
        for (int i = 16; i < n; i++)
            apb(1'b1, 12'h01c, {23'h0, 1'(i == n - 1), p[i]});
        while (exp_q.size() != 0)
            @(posedge mclk);
        repeat (2) @(posedge mclk);
        nf++;
        apb(1'b0, 12'h020, 32'h0);
        `BFA_CHK(r[4:0], 5'h08)
        `BFA_CHK(r[31:16], 16'(nf))
    endtask
    initial begin
        void'($urandom(32'hc2555d58));
        rst_b = 1'b0;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        foreach (rv[i]) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            `BFA_CHK(r, rv[i])
        end
        apb(1'b0, 12'h024, 32'h0);
        `BFA_CHK({e, r}, 33'h100000000)
        apb(1'b1, 12'h01c, 32'h0a5);
        apb(1'b0, 12'h020, 32'h0);
        `BFA_CHK(r[4], 1'b1)
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b0, 12'h020, 32'h0);
        `BFA_CHK(r[4], 1'b0)
        for (int k = 0; k < 4; k++)
            frame(k == 0 ? 1 : 6 * k, 1'(k % 2));
        wrap_up();
    end
endmodule
`default_nettype wire
